/* design/dwsc_pkg.sv */
// constants and notes on behaviour for the dual wiper serial control block
// Notes on behaviour
// - left shift of a zero wiper loads code one.
// - left shift of a wiper at or above midscale loads full scale.
// - otherwise +6 dB is one-bit left shift, -6 dB one-bit right shift.
// - right shift drops the low bit, no rounding, settles at zero.
// - sixteen words: two presets, thirteen user words, one tolerance word.
// - user words are 16 bits, written by command 3, read by command 9.
// - word 15 is factory set and read only; words 0 to 14 all writable by command 3.
// - tolerance word is sign, seven integer bits, eight fraction bits.
// - presets load wipers at power-on, command 1, command 8, preset pulse.
// - command 1 leaves a read power state until a no-operation arrives.
// - commands 10 and 9 put wiper or word on the output next frame.
// - two chained devices take 48 bits; the last 24 stay here.
// - serial output is released whenever select is high.
// - frame is 24 bits msb first: command, address, data.
// - lowest address bit picks channel 1 or channel 2.
// - command 11 loads low ten data bits into the chosen wiper.
// - command 3 writes all sixteen data bits into the addressed word.
// - serial clock modes idle-high second edge and idle-low first edge.
// - a command acts only when select rises at frame end.
// - a save takes about 25 ms, input locked, done output signals end.
// - write protect blocks wiper changes except restores and the preset pin midscale hold.
// - preset pin low holds midscale; presets load on its release.
package dwsc_pkg;
    localparam int WIPER_W    = 10;
    localparam int WORD_W     = 16;
    localparam int FRAME_W    = 24;
    localparam int ADDR_W     = 4;
    localparam int CMD_W      = 4;
    localparam int CMD_MSB    = 23;
    localparam int ADDR_MSB   = 19;
    localparam int DATA_MSB   = 15;
    localparam int WORDS      = 16;
    localparam logic [3:0] CMD_NOP        = 4'h0;
    localparam logic [3:0] CMD_RESTORE    = 4'h1;
    localparam logic [3:0] CMD_SAVE       = 4'h2;
    localparam logic [3:0] CMD_STORE      = 4'h3;
    localparam logic [3:0] CMD_DEC6       = 4'h4;
    localparam logic [3:0] CMD_DEC6_ALL   = 4'h5;
    localparam logic [3:0] CMD_DEC1       = 4'h6;
    localparam logic [3:0] CMD_DEC1_ALL   = 4'h7;
    localparam logic [3:0] CMD_RESET_ALL  = 4'h8;
    localparam logic [3:0] CMD_READ_NV    = 4'h9;
    localparam logic [3:0] CMD_READ_WIPER = 4'hA;
    localparam logic [3:0] CMD_WRITE      = 4'hB;
    localparam logic [3:0] CMD_INC6       = 4'hC;
    localparam logic [3:0] CMD_INC6_ALL   = 4'hD;
    localparam logic [3:0] CMD_INC1       = 4'hE;
    localparam logic [3:0] CMD_INC1_ALL   = 4'hF;
    localparam logic [3:0] ADDR_PRESET1   = 4'h0;
    localparam logic [3:0] ADDR_PRESET2   = 4'h1;
    localparam logic [3:0] ADDR_USER_LO   = 4'h2;
    localparam logic [3:0] ADDR_USER_HI   = 4'hE;
    localparam logic [3:0] ADDR_TOLERANCE = 4'hF;
    localparam logic [9:0]  WIPER_ZERO = 10'h000;
    localparam logic [9:0]  WIPER_ONE  = 10'h001;
    localparam logic [9:0]  WIPER_MID  = 10'h200;
    localparam logic [9:0]  WIPER_FULL = 10'h3FF;
    localparam logic [15:0] PRESET_RESET = 16'h0200;
    localparam logic [15:0] WORD_RESET   = 16'h0000;
    localparam int SAVE_TIME_MS = 25;
    localparam int CLK_KHZ      = 200000;
    localparam int SAVE_CYCLES  = SAVE_TIME_MS * CLK_KHZ;
endpackage

/* design/dwsc_top.sv */
// dual wiper serial command interpreter with nonvolatile word store
`timescale 1ns/1ps
module dwsc_top #(
    parameter int          SAVE_CYCLES   = dwsc_pkg::SAVE_CYCLES,
    // arbitrary neutral factory tolerance value
    parameter logic [15:0] TOLERANCE_VAL = 16'h0000
) (
    // clock and reset
    input  wire logic        mclk,
    input  wire logic        sys_rst,
    // serial link
    input  wire logic        serial_clk,
    input  wire logic        chip_select_n,
    input  wire logic        serial_in,
    output logic             serial_out_o,
    output logic             serial_out_oe,
    // control pins
    input  wire logic        preset_strobe_n,
    input  wire logic        write_protect_n,
    output logic             save_ready,
    output logic             read_power_state,
    // wiper values
    output logic [9:0]       wiper_register_1,
    output logic [9:0]       wiper_register_2
);
    localparam int SC_W = $clog2(SAVE_CYCLES + 1);

    // ------------------------------------------------------------
    // input synchronisers
    // ------------------------------------------------------------
    logic [1:0] clk_s_ff;
    logic [1:0] cs_s_ff;
    logic [1:0] sdi_s_ff;
    logic [1:0] pr_s_ff;
    logic [1:0] wp_s_ff;
    logic       clk_d_ff;
    logic       cs_d_ff;
    logic       pr_d_ff;

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            clk_s_ff <= 2'h0;
            cs_s_ff  <= 2'h3;
            sdi_s_ff <= 2'h0;
            pr_s_ff  <= 2'h3;
            wp_s_ff  <= 2'h3;
            clk_d_ff <= 1'b0;
            cs_d_ff  <= 1'b1;
            pr_d_ff  <= 1'b1;
        end else begin
            clk_s_ff <= {clk_s_ff[0], serial_clk};
            cs_s_ff  <= {cs_s_ff[0], chip_select_n};
            sdi_s_ff <= {sdi_s_ff[0], serial_in};
            pr_s_ff  <= {pr_s_ff[0], preset_strobe_n};
            wp_s_ff  <= {wp_s_ff[0], write_protect_n};
            clk_d_ff <= clk_s_ff[1];
            cs_d_ff  <= cs_s_ff[1];
            pr_d_ff  <= pr_s_ff[1];
        end
    end

    logic cs_n;
    logic clk_rise;
    logic clk_fall;
    logic frame_end;
    logic pr_low;
    logic pr_rise;
    logic wp_on;

    assign cs_n      = cs_s_ff[1];
    assign clk_rise  = clk_s_ff[1] & ~clk_d_ff;
    assign clk_fall  = ~clk_s_ff[1] & clk_d_ff;
    assign frame_end = cs_n & ~cs_d_ff;
    assign pr_low    = ~pr_s_ff[1];
    assign pr_rise   = pr_s_ff[1] & ~pr_d_ff;
    assign wp_on     = ~wp_s_ff[1];

    // ------------------------------------------------------------
    // serial shift register
    // ------------------------------------------------------------
    // both modes sample on the rising edge and shift out on falling;
    // clock idle level at select fall decides whether bit 23 shows early
    logic [23:0] shift_ff;
    logic        out_bit_ff;
    logic        busy;
    logic        load_rd_ff;
    logic [15:0] load_val_ff;

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            shift_ff <= 24'h000000;
        end else if (load_rd_ff) begin
            // one cycle after select rises, so the reply leads the next frame
            shift_ff <= {8'h00, load_val_ff};
        end else if (~cs_n && clk_rise && !busy) begin
            shift_ff <= {shift_ff[22:0], sdi_s_ff[1]};
        end
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            out_bit_ff <= 1'b1;
        end else if (~cs_n & cs_d_ff & ~clk_s_ff[1]) begin
            out_bit_ff <= shift_ff[23];
        end else if (~cs_n && clk_fall) begin
            out_bit_ff <= shift_ff[23];
        end
    end

    // open drain: enable only to pull low while selected
    assign serial_out_o  = 1'b0;
    assign serial_out_oe = ~cs_n & ~out_bit_ff;

    // ------------------------------------------------------------
    // frame decode
    // ------------------------------------------------------------
    logic [3:0]  cmd;
    logic [3:0]  addr;
    logic [15:0] data;
    logic        ch;

    assign cmd  = shift_ff[dwsc_pkg::CMD_MSB -: dwsc_pkg::CMD_W];
    assign addr = shift_ff[dwsc_pkg::ADDR_MSB -: dwsc_pkg::ADDR_W];
    assign data = shift_ff[dwsc_pkg::DATA_MSB:0];
    assign ch   = addr[0];

    // ------------------------------------------------------------
    // nonvolatile word store
    // ------------------------------------------------------------
    logic [15:0]    nv_mem_ff [dwsc_pkg::WORDS];
    logic [SC_W-1:0] save_cnt_ff;
    logic            save_pend_ff;
    logic [3:0]      save_addr_ff;
    logic [15:0]     save_data_ff;

    assign busy       = save_pend_ff;
    assign save_ready = ~save_pend_ff;

    function automatic logic user_writable(input logic [3:0] a);
        return a <= dwsc_pkg::ADDR_USER_HI;
    endfunction

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            save_pend_ff <= 1'b0;
            save_cnt_ff  <= '0;
            save_addr_ff <= 4'h0;
            save_data_ff <= 16'h0000;
        end else if (save_pend_ff) begin
            if (save_cnt_ff == SC_W'(SAVE_CYCLES - 1)) begin
                save_pend_ff <= 1'b0;
            end
            save_cnt_ff <= save_cnt_ff + SC_W'(1);
        end else if (frame_end && cmd == dwsc_pkg::CMD_STORE && user_writable(addr)) begin
            save_pend_ff <= 1'b1;
            save_cnt_ff  <= '0;
            save_addr_ff <= addr;
            save_data_ff <= data;
        end else if (frame_end && cmd == dwsc_pkg::CMD_SAVE) begin
            save_pend_ff <= 1'b1;
            save_cnt_ff  <= '0;
            save_addr_ff <= {3'h0, ch};
            save_data_ff <= {6'h00, ch ? wiper_register_2 : wiper_register_1};
        end
    end

    // write lands when the save time ends
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            for (int i = 0; i < dwsc_pkg::WORDS; i++) begin
                nv_mem_ff[i] <= dwsc_pkg::WORD_RESET;
            end
            nv_mem_ff[dwsc_pkg::ADDR_PRESET1] <= dwsc_pkg::PRESET_RESET;
            nv_mem_ff[dwsc_pkg::ADDR_PRESET2] <= dwsc_pkg::PRESET_RESET;
        end else if (save_pend_ff && save_cnt_ff == SC_W'(SAVE_CYCLES - 1)) begin
            nv_mem_ff[save_addr_ff] <= save_data_ff;
        end
    end

    // sign, 7-bit integer, 8-bit fraction percent
    logic [15:0] tolerance_word;
    assign tolerance_word = TOLERANCE_VAL;

    // ------------------------------------------------------------
    // read-back capture
    // ------------------------------------------------------------
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            load_rd_ff  <= 1'b0;
            load_val_ff <= 16'h0000;
        end else if (frame_end) begin
            load_rd_ff <= 1'b0;
            if (!busy && cmd == dwsc_pkg::CMD_READ_NV) begin
                load_rd_ff  <= 1'b1;
                load_val_ff <= (addr == dwsc_pkg::ADDR_TOLERANCE) ? tolerance_word
                                                                  : nv_mem_ff[addr];
            end else if (!busy && cmd == dwsc_pkg::CMD_READ_WIPER) begin
                load_rd_ff  <= 1'b1;
                load_val_ff <= {6'h00, ch ? wiper_register_2 : wiper_register_1};
            end
        end else begin
            load_rd_ff <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // read power state
    // ------------------------------------------------------------
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            read_power_state <= 1'b0;
        end else if (frame_end && !busy && cmd == dwsc_pkg::CMD_RESTORE) begin
            read_power_state <= 1'b1;
        end else if (frame_end && !busy && cmd == dwsc_pkg::CMD_NOP) begin
            read_power_state <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // wiper arithmetic
    // ------------------------------------------------------------
    function automatic logic [9:0] shl6(input logic [9:0] v);
        if (v == dwsc_pkg::WIPER_ZERO) begin
            return dwsc_pkg::WIPER_ONE;
        end else if (v >= dwsc_pkg::WIPER_MID) begin
            return dwsc_pkg::WIPER_FULL;
        end
        return {v[8:0], 1'b0};
    endfunction

    function automatic logic [9:0] shr6(input logic [9:0] v);
        return {1'b0, v[9:1]};
    endfunction

    function automatic logic [9:0] inc1(input logic [9:0] v);
        return (v == dwsc_pkg::WIPER_FULL) ? v : v + 10'h001;
    endfunction

    function automatic logic [9:0] dec1(input logic [9:0] v);
        return (v == dwsc_pkg::WIPER_ZERO) ? v : v - 10'h001;
    endfunction

    function automatic logic [9:0] apply(input logic [3:0] c, input logic [9:0] v,
                                         input logic [15:0] d);
        unique case (c)
            dwsc_pkg::CMD_WRITE:                        return d[9:0];
            dwsc_pkg::CMD_INC6, dwsc_pkg::CMD_INC6_ALL: return shl6(v);
            dwsc_pkg::CMD_DEC6, dwsc_pkg::CMD_DEC6_ALL: return shr6(v);
            dwsc_pkg::CMD_INC1, dwsc_pkg::CMD_INC1_ALL: return inc1(v);
            dwsc_pkg::CMD_DEC1, dwsc_pkg::CMD_DEC1_ALL: return dec1(v);
            default:                                    return v;
        endcase
    endfunction

    function automatic logic is_all(input logic [3:0] c);
        return c == dwsc_pkg::CMD_INC6_ALL || c == dwsc_pkg::CMD_DEC6_ALL ||
               c == dwsc_pkg::CMD_INC1_ALL || c == dwsc_pkg::CMD_DEC1_ALL;
    endfunction

    // ------------------------------------------------------------
    // wiper registers
    // ------------------------------------------------------------
    // power-on restore happens on the first cycle after reset release
    logic       por_ff;
    logic       restore;
    logic       restore1;
    logic       restore2;
    logic       exec;
    logic [9:0] nxt_w1;
    logic [9:0] nxt_w2;

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            por_ff <= 1'b1;
        end else begin
            por_ff <= 1'b0;
        end
    end

    assign exec     = frame_end && !busy;
    assign restore  = por_ff || pr_rise || (exec && cmd == dwsc_pkg::CMD_RESET_ALL);
    assign restore1 = restore || (exec && cmd == dwsc_pkg::CMD_RESTORE && !ch);
    assign restore2 = restore || (exec && cmd == dwsc_pkg::CMD_RESTORE && ch);

    always_comb begin
        nxt_w1 = wiper_register_1;
        nxt_w2 = wiper_register_2;
        if (exec && !wp_on) begin
            if (is_all(cmd) || !ch) begin
                nxt_w1 = apply(cmd, wiper_register_1, data);
            end
            if (is_all(cmd) || ch) begin
                nxt_w2 = apply(cmd, wiper_register_2, data);
            end
        end
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            wiper_register_1 <= dwsc_pkg::WIPER_MID;
            wiper_register_2 <= dwsc_pkg::WIPER_MID;
        end else if (pr_low) begin
            wiper_register_1 <= dwsc_pkg::WIPER_MID;
            wiper_register_2 <= dwsc_pkg::WIPER_MID;
        end else begin
            wiper_register_1 <= restore1 ? nv_mem_ff[dwsc_pkg::ADDR_PRESET1][9:0] : nxt_w1;
            wiper_register_2 <= restore2 ? nv_mem_ff[dwsc_pkg::ADDR_PRESET2][9:0] : nxt_w2;
        end
    end
endmodule

/* verif/dwsc_host_model.sv */
// host-side serial master model driving the dual wiper block
`timescale 1ns/1ps
module dwsc_host_model (
    // clock
    input  wire logic        mclk,
    // serial link
    output logic             serial_clk,
    output logic             chip_select_n,
    output logic             serial_in,
    input  wire logic        serial_out_oe
);
    logic [47:0] rx_bits = '0;
    // open-drain output with a pull-up on the board
    wire         line_w  = serial_out_oe ? 1'b0 : 1'b1;

    initial begin
        serial_clk    = 1'b0;
        chip_select_n = 1'b1;
        serial_in     = 1'b0;
    end

    task automatic half();
        repeat (16) @(posedge mclk);
    endtask

    // clock parks at its idle level before select falls, so no stray edge inside a frame
    task automatic xfer(input logic [47:0] bits, input int n, input logic idle);
        serial_clk <= idle;
        half();
        chip_select_n <= 1'b0;
        half();
        for (int i = n - 1; i >= 0; i--) begin
            serial_clk <= 1'b0;
            serial_in  <= bits[i];
            half();
            serial_clk <= 1'b1;
            rx_bits    <= {rx_bits[46:0], line_w};
            half();
        end
        serial_clk <= idle;
        serial_in  <= ~serial_in;
        half();
        chip_select_n <= 1'b1;
        half();
    endtask
endmodule

/* verif/dwsc_top_chk.sv */
// assertion checker for the dual wiper serial control block
`timescale 1ns/1ps
module dwsc_top_chk #(
    parameter int          SAVE_CYCLES   = 50,
    parameter logic [15:0] TOLERANCE_VAL = 16'h0000
) (
    // clock and reset
    input wire logic       mclk,
    input wire logic       sys_rst,
    // serial link
    input wire logic       serial_clk,
    input wire logic       chip_select_n,
    input wire logic       serial_in,
    input wire logic       serial_out_o,
    input wire logic       serial_out_oe,
    // control pins
    input wire logic       preset_strobe_n,
    input wire logic       write_protect_n,
    input wire logic       save_ready,
    input wire logic       read_power_state,
    // wiper values
    input wire logic [9:0] wiper_register_1,
    input wire logic [9:0] wiper_register_2
);
    int save_cnt;
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            save_cnt <= 0;
        end else begin
            save_cnt <= save_ready ? 0 : save_cnt + 1;
        end
    end
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (sys_rst);
    // ----------------------------------------
    // assertions
    // ----------------------------------------
    AST_OE_IDLE: assert property (chip_select_n [*6] |-> !serial_out_oe)
        else $error("serial out driven while deselected");
    AST_OUT_ZERO: assert property (serial_out_o == 1'b0)
        else $error("open drain data not low");
    AST_PRESET_MID: assert property ((!preset_strobe_n) [*6] |->
        wiper_register_1 == 10'h200 && wiper_register_2 == 10'h200)
        else $error("wipers not midscale under preset");
    AST_FRAME_QUIET: assert property ((!chip_select_n && preset_strobe_n) [*8] |->
        $stable(wiper_register_1) && $stable(wiper_register_2))
        else $error("wiper moved inside a frame");
    AST_WIPER_AT_END: assert property ($changed(wiper_register_1) && preset_strobe_n
        && $past(preset_strobe_n, 8) |-> chip_select_n)
        else $error("wiper one changed with select low");
    AST_RPS_AT_END: assert property ($changed(read_power_state) |-> chip_select_n)
        else $error("power state changed with select low");
    AST_SAVE_LEN: assert property ($rose(save_ready) |->
        save_cnt >= SAVE_CYCLES - 2 && save_cnt <= SAVE_CYCLES + 2)
        else $error("save time wrong");
    AST_SAVE_LOCK: assert property (!save_ready && !$past(save_ready) && preset_strobe_n
        |-> $stable(wiper_register_1) && $stable(wiper_register_2))
        else $error("wiper moved during save");
endmodule
bind dwsc_top dwsc_top_chk #(.SAVE_CYCLES(SAVE_CYCLES), .TOLERANCE_VAL(TOLERANCE_VAL)) u_chk (
    .mclk(mclk), .sys_rst(sys_rst), .serial_clk(serial_clk), .chip_select_n(chip_select_n),
    .serial_in(serial_in), .serial_out_o(serial_out_o), .serial_out_oe(serial_out_oe),
    .preset_strobe_n(preset_strobe_n), .write_protect_n(write_protect_n),
    .save_ready(save_ready), .read_power_state(read_power_state),
    .wiper_register_1(wiper_register_1), .wiper_register_2(wiper_register_2)
);

/* verif/tb.sv */
// self-checking testbench for the dual wiper serial control block
`timescale 1ns/1ps
`define CHK(g, e, m) begin checks++; if ((g) !== (e)) begin err_count++; \
    $display("[ERR] %0t %s", $time, m); end end
module tb;
    localparam logic [15:0] TOL = 16'h8A40; // arbitrary factory word, sign bit set
    logic        mclk            = 1'b0;
    logic        sys_rst         = 1'b1;
    logic        preset_strobe_n = 1'b1;
    logic        write_protect_n = 1'b1;
    logic        serial_clk, chip_select_n, serial_in, out_oe, save_ready, rps;
    logic [9:0]  w1, w2, e1, e2;
    logic        erps = 1'b0;
    logic        m3   = 1'b0;
    logic [15:0] rd;
    logic [45:0] note;
    logic [45:0] exp_q[$];
    int          err_count = 0;
    int          checks    = 0;
    event        sample_ev;

    always #2.5 mclk = ~mclk;

    dwsc_top #(.SAVE_CYCLES(2000), .TOLERANCE_VAL(TOL)) dut (
        .mclk(mclk), .sys_rst(sys_rst), .serial_clk(serial_clk),
        .chip_select_n(chip_select_n), .serial_in(serial_in), .serial_out_o(),
        .serial_out_oe(out_oe), .preset_strobe_n(preset_strobe_n),
        .write_protect_n(write_protect_n), .save_ready(save_ready),
        .read_power_state(rps), .wiper_register_1(w1), .wiper_register_2(w2));
    dwsc_host_model host (.mclk(mclk), .serial_clk(serial_clk),
        .chip_select_n(chip_select_n), .serial_in(serial_in), .serial_out_oe(out_oe));

    task automatic summarize();
        if (err_count == 0 && checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // step past the edge so the design's updates have landed
    task automatic put(input logic ck, input logic [23:0] rx);
        #1;
        exp_q.push_back({ck, erps, rx, e1, e2});
        -> sample_ev;
    endtask
    task automatic settle();
        int n = 0;
        repeat (8) @(posedge mclk);
        while (save_ready !== 1'b1 && n < 5000) begin
            @(posedge mclk);
            n++;
        end
        if (n == 5000) begin
            err_count++;
            $display("[ERR] %0t save never ended", $time);
            summarize();
        end
    endtask
    task automatic go(input logic [23:0] f, input logic ck = 1'b0, input logic [23:0] rx = '0);
        host.xfer({24'h000000, f}, 24, m3);
        settle();
        put(ck, rx);
    endtask

    always @(sample_ev) begin
        note = exp_q.pop_front();
        `CHK(w1, note[19:10], "wiper one")
        `CHK(w2, note[9:0], "wiper two")
        `CHK(rps, note[44], "power state")
        if (note[45]) `CHK(host.rx_bits[23:0], note[43:20], "serial reply")
    end

    // ----------------------------------------
    // stimulus
    // ----------------------------------------
    initial begin
        void'($urandom(32'h464E));
        repeat (20) @(posedge mclk);
        sys_rst <= 1'b0;
        repeat (8) @(posedge mclk);
        e1 = 10'h200;
        e2 = 10'h200;
        put(1'b0, '0);
        e1 = 10'h100;
        go(24'hB0FD00);
        e2 = 10'h003;
        go(24'hB10003);
        e1 = 10'h200;
        go(24'hC00000);
        e1 = 10'h3FF;
        repeat (2) go(24'hC00000);
        e1 = 10'h000;
        go(24'hB00000);
        e1 = 10'h001;
        go(24'hC00000);
        e2 = 10'h001;
        go(24'h410000);
        e2 = 10'h000;
        repeat (2) go(24'h410000);
        // random wiper write in the idle-high clock mode
        m3 = 1'b1;
        rd = 16'($urandom);
        e1 = rd[9:0];
        go({8'hB0, rd});
        m3 = 1'b0;
        go(24'hA00000);
        go(24'h000000, 1'b1, {14'h0000, e1});
        rd = 16'($urandom);
        host.xfer({32'hB0_0000_03, 4'h2, rd}, 24, 1'b0);
        go(24'hB00155);
        go(24'h920000);
        go(24'h000000, 1'b1, {8'h00, rd});
        go(24'h3F1234);
        go(24'h9F0000);
        go(24'h000000, 1'b1, {8'h00, TOL});
        go(24'h300123);
        e1 = 10'h123;
        erps = 1'b1;
        go(24'h100000);
        erps = 1'b0;
        go(24'h000000);
        e1 = 10'h0AA;
        go(24'hB000AA);
        @(posedge mclk) write_protect_n <= 1'b0;
        go(24'hB10155);
        go(24'hF00000);
        e1 = 10'h123;
        e2 = 10'h200;
        go(24'h800000);
        @(posedge mclk) write_protect_n <= 1'b1;
        e1 = 10'h0F0;
        go(24'hB000F0);
        @(posedge mclk) preset_strobe_n <= 1'b0;
        repeat (20) @(posedge mclk);
        e1 = 10'h200;
        put(1'b0, '0);
        @(posedge mclk) preset_strobe_n <= 1'b1;
        repeat (20) @(posedge mclk);
        e1 = 10'h123;
        put(1'b0, '0);
        e2 = 10'h311;
        host.xfer(48'hB00200_B10311, 48, 1'b0);
        settle();
        put(1'b1, 24'hB00200);
        go(24'h000000);
        repeat (10) @(posedge mclk);
        summarize();
    end
endmodule
